//--- eiv_pkg.sv
// Package with constants for the extended interrupt vectoring block.
package eiv_pkg;
	// ==========================================================
	// Special function register addresses.
	localparam logic [7:0] ADDR_INT_ENABLE_PRIMARY = 8'ha8;
	localparam logic [7:0] ADDR_EXT_ENABLE_ONE = 8'he6;
	localparam logic [7:0] ADDR_EXT_ENABLE_TWO = 8'he7;
	localparam logic [7:0] ADDR_EXT_PRIORITY_ONE = 8'hf6;
	localparam logic [7:0] ADDR_EXT_PRIORITY_TWO = 8'hf7;
	localparam logic [7:0] ADDR_RTC_INDEX = 8'hac;
	localparam logic [7:0] ADDR_RTC_DATA = 8'had;
	// ==========================================================
	// Field positions and reset values.
	localparam int GLOBAL_IRQ_GATE_BIT = 7;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] RTC_CONTROL_INDEX = 8'h04;
	localparam int RTC_ALARM_BIT = 2;
	localparam int RTC_OSC_FAIL_BIT = 5;
	// ==========================================================
	// Source table: slot k has order FIRST_ORDER + k.
	localparam int NUM_SRC = 12;
	localparam logic [4:0] FIRST_ORDER = 5'h0a;
	localparam logic [15:0] FIRST_VECTOR = 16'h0053;
	localparam logic [15:0] LAST_VECTOR = 16'h00ab;
	localparam logic [15:0] VECTOR_STEP = 16'h0008;
	localparam int ENABLE_BIT_OFFSET = 3;
	localparam logic [11:0] RESERVED_SLOTS = 12'h108;
	localparam int SLOT_SUPPLY_WARN = 5;
	localparam int SLOT_PORT_MATCH = 6;
	localparam int SLOT_OSC_FAIL = 7;
	localparam logic [15:0] OSC_FAIL_VECTOR = 16'h008b;
	localparam logic [4:0] OSC_FAIL_ORDER = 5'h11;
endpackage

//--- eiv_vectoring.sv
// Extended interrupt vectoring: enables, priorities, arbitration and vector output.
`timescale 1ns/1ns
module eiv_vectoring (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	input wire logic [11:0] i_src_pending,
	input wire logic i_rtc_alarm_evt,
	input wire logic i_rtc_osc_fail_evt,
	output logic o_irq_req,
	output logic o_irq_high,
	output logic [15:0] o_irq_vector,
	output logic [4:0] o_irq_order
);
	// ==========================================================
	// Register state.
	logic [7:0] int_enable_primary_q, int_enable_primary_d;
	logic [15:0] ext_enable_q, ext_enable_d;
	logic [15:0] ext_priority_q, ext_priority_d;
	logic [7:0] rtc_index_q, rtc_index_d;
	logic rtc_alarm_q, rtc_alarm_d;
	logic rtc_osc_fail_q, rtc_osc_fail_d;
	logic [7:0] rdata_d;
	logic rtc_sel;

	assign rtc_sel = (rtc_index_q == eiv_pkg::RTC_CONTROL_INDEX);

	always_comb begin
		int_enable_primary_d = int_enable_primary_q;
		ext_enable_d = ext_enable_q;
		ext_priority_d = ext_priority_q;
		rtc_index_d = rtc_index_q;
		rtc_alarm_d = rtc_alarm_q;
		rtc_osc_fail_d = rtc_osc_fail_q;
		if (i_sfr_wr) begin
			unique case (i_sfr_addr)
				eiv_pkg::ADDR_INT_ENABLE_PRIMARY: int_enable_primary_d = i_sfr_wdata;
				eiv_pkg::ADDR_EXT_ENABLE_ONE: ext_enable_d[7:0] = i_sfr_wdata;
				eiv_pkg::ADDR_EXT_ENABLE_TWO: ext_enable_d[15:8] = i_sfr_wdata;
				eiv_pkg::ADDR_EXT_PRIORITY_ONE: ext_priority_d[7:0] = i_sfr_wdata;
				eiv_pkg::ADDR_EXT_PRIORITY_TWO: ext_priority_d[15:8] = i_sfr_wdata;
				eiv_pkg::ADDR_RTC_INDEX: rtc_index_d = i_sfr_wdata;
				eiv_pkg::ADDR_RTC_DATA: begin
					if (rtc_sel) begin
						rtc_alarm_d = i_sfr_wdata[eiv_pkg::RTC_ALARM_BIT];
						rtc_osc_fail_d = i_sfr_wdata[eiv_pkg::RTC_OSC_FAIL_BIT];
					end
				end
				default: begin
				end
			endcase
		end
		// A hardware event in the same cycle as a software clear must not be lost.
		if (i_rtc_alarm_evt) begin
			rtc_alarm_d = 1'b1;
		end
		if (i_rtc_osc_fail_evt) begin
			rtc_osc_fail_d = 1'b1;
		end
	end

	always_comb begin
		rdata_d = eiv_pkg::RESET_BYTE;
		unique case (i_sfr_addr)
			eiv_pkg::ADDR_INT_ENABLE_PRIMARY: rdata_d = int_enable_primary_q;
			eiv_pkg::ADDR_EXT_ENABLE_ONE: rdata_d = ext_enable_q[7:0];
			eiv_pkg::ADDR_EXT_ENABLE_TWO: rdata_d = ext_enable_q[15:8];
			eiv_pkg::ADDR_EXT_PRIORITY_ONE: rdata_d = ext_priority_q[7:0];
			eiv_pkg::ADDR_EXT_PRIORITY_TWO: rdata_d = ext_priority_q[15:8];
			eiv_pkg::ADDR_RTC_INDEX: rdata_d = rtc_index_q;
			eiv_pkg::ADDR_RTC_DATA: begin
				if (rtc_sel) begin
					rdata_d[eiv_pkg::RTC_ALARM_BIT] = rtc_alarm_q;
					rdata_d[eiv_pkg::RTC_OSC_FAIL_BIT] = rtc_osc_fail_q;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			int_enable_primary_q <= eiv_pkg::RESET_BYTE;
			ext_enable_q <= 16'h0000;
			ext_priority_q <= 16'h0000;
			rtc_index_q <= eiv_pkg::RESET_BYTE;
			rtc_alarm_q <= 1'b0;
			rtc_osc_fail_q <= 1'b0;
			o_sfr_rdata <= eiv_pkg::RESET_BYTE;
		end else begin
			int_enable_primary_q <= int_enable_primary_d;
			ext_enable_q <= ext_enable_d;
			ext_priority_q <= ext_priority_d;
			rtc_index_q <= rtc_index_d;
			rtc_alarm_q <= rtc_alarm_d;
			rtc_osc_fail_q <= rtc_osc_fail_d;
			o_sfr_rdata <= rdata_d;
		end
	end

	// ==========================================================
	// Request gating and arbitration.
	// Pending levels are never cleared here: the supply warning and port match
	// have no clearable flag, so masking is the only way to stop their calls.
	logic [11:0] pending;
	logic [11:0] active;
	logic [11:0] active_high;
	logic gate;

	function automatic logic [3:0] first_set(input logic [11:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int k = eiv_pkg::NUM_SRC - 1; k >= 0; k--) begin
			if (v[k]) begin
				idx = 4'(k);
			end
		end
		return idx;
	endfunction

	always_comb begin
		pending = i_src_pending;
		pending[eiv_pkg::SLOT_OSC_FAIL] = rtc_osc_fail_q;
		pending = pending & ~eiv_pkg::RESERVED_SLOTS;
	end

	assign gate = int_enable_primary_q[eiv_pkg::GLOBAL_IRQ_GATE_BIT];
	assign active = gate ? (pending & ext_enable_q[eiv_pkg::ENABLE_BIT_OFFSET +: 12]) : 12'h000;
	assign active_high = active & ext_priority_q[eiv_pkg::ENABLE_BIT_OFFSET +: 12];

	logic req_d, high_d;
	logic [3:0] slot_d;
	logic [15:0] vector_d;
	logic [4:0] order_d;

	always_comb begin
		req_d = |active;
		high_d = |active_high;
		slot_d = high_d ? first_set(active_high) : first_set(active);
		vector_d = eiv_pkg::FIRST_VECTOR + (16'(slot_d) << 3);
		order_d = eiv_pkg::FIRST_ORDER + 5'(slot_d);
	end

	// A fresh decision is registered every cycle, so a flag left set after return
	// shows as a request again on the next edge.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq_req <= 1'b0;
			o_irq_high <= 1'b0;
			o_irq_vector <= eiv_pkg::FIRST_VECTOR;
			o_irq_order <= eiv_pkg::FIRST_ORDER;
		end else begin
			o_irq_req <= req_d;
			o_irq_high <= high_d;
			o_irq_vector <= vector_d;
			o_irq_order <= order_d;
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	sequence s_write_enable_zero;
		i_sfr_wr && i_sfr_addr == eiv_pkg::ADDR_INT_ENABLE_PRIMARY && i_sfr_wdata == 8'h00;
	endsequence

	sequence s_enable_cleared;
		int_enable_primary_q == eiv_pkg::RESET_BYTE ##1 !o_irq_req;
	endsequence

	AST_VECTOR_RANGE: assert property (o_irq_req |-> o_irq_vector >= eiv_pkg::FIRST_VECTOR &&
		o_irq_vector <= eiv_pkg::LAST_VECTOR && o_irq_vector[2:0] == 3'h3)
		else $error("vector outside extended range");
	AST_ORDER_MATCH: assert property (o_irq_req |->
		o_irq_vector == eiv_pkg::FIRST_VECTOR + 16'(o_irq_order - eiv_pkg::FIRST_ORDER) * eiv_pkg::VECTOR_STEP)
		else $error("order and vector disagree");
	AST_SUPPLY_PERSIST: assert property ((gate && ext_enable_q[eiv_pkg::SLOT_SUPPLY_WARN + 3] &&
		i_src_pending[eiv_pkg::SLOT_SUPPLY_WARN] && !i_sfr_wr) |=> o_irq_req)
		else $error("supply warning request lost");
	AST_MASK_BLOCKS: assert property ((active == 12'h000) |=> !o_irq_req)
		else $error("masked source requested");
	AST_OSC_FAIL_SLOT: assert property ((gate && rtc_osc_fail_q &&
		ext_enable_q[eiv_pkg::SLOT_OSC_FAIL + 3] && ext_priority_q[10] && active_high == 12'h080)
		|=> o_irq_vector == eiv_pkg::OSC_FAIL_VECTOR && o_irq_order == eiv_pkg::OSC_FAIL_ORDER)
		else $error("oscillator fail vector wrong");
	AST_RESET_CLEAR_SEQ: assert property (s_write_enable_zero |=> s_enable_cleared)
		else $error("primary enable did not clear");
	AST_NO_RESERVED: assert property (o_irq_req |-> o_irq_order != 5'h0d && o_irq_order != 5'h12)
		else $error("reserved slot requested");
	AST_GLOBAL_GATE: assert property (!gate |=> !o_irq_req)
		else $error("request with global gate off");
	AST_HIGH_FIRST: assert property (active_high != 12'h000 |=> o_irq_high && o_irq_req)
		else $error("high priority not served first");
	AST_EVERY_CYCLE: assert property (active != 12'h000 |=> o_irq_req)
		else $error("pending request not raised");

	// A clear of the indirect failure flag loses to a new failure event in the same cycle.
	AST_OSC_SET_WINS: assert property (i_rtc_osc_fail_evt |=> rtc_osc_fail_q)
		else $error("oscillator fail event lost to a clear");
	AST_PRIMARY_READBACK: assert property ((i_sfr_addr == eiv_pkg::ADDR_INT_ENABLE_PRIMARY && !i_sfr_wr)
		|=> o_sfr_rdata == int_enable_primary_q)
		else $error("primary enable read back wrong");
	// Port match has no flag of its own, so its input level alone must raise a request.
	AST_PORT_MATCH_REQ: assert property ((gate && i_src_pending[eiv_pkg::SLOT_PORT_MATCH] &&
		ext_enable_q[eiv_pkg::SLOT_PORT_MATCH + eiv_pkg::ENABLE_BIT_OFFSET]) |=> o_irq_req)
		else $error("port match request lost");
endmodule // eiv_vectoring

//--- eiv_core_model.sv
// Behavioural processor core that takes vector calls from the interrupt block.
`timescale 1ns/1ns
module eiv_core_model #(
	parameter int CALL_CYCLES = 7
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_irq_req,
	input wire logic [15:0] i_irq_vector,
	output int o_calls,
	output logic [15:0] o_last_vector
);
	int busy;
	// ==========================================================
	// A call in progress hides new requests, so a short pulse may go unserved.
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_calls <= 0;
			busy <= 0;
			o_last_vector <= 16'h0000;
		end else if (busy > 0) begin
			busy <= busy - 1;
		end else if (i_irq_req) begin
			o_calls <= o_calls + 1;
			o_last_vector <= i_irq_vector;
			busy <= CALL_CYCLES;
		end
	end
endmodule // eiv_core_model

//--- eiv_vectoring_tb_top.sv
// Self-checking testbench for the extended interrupt vectoring block.
`timescale 1ns/1ns
module eiv_vectoring_tb_top;
	logic i_clock = 0, i_rst_n = 0, wr = 0, alarm = 0, oscf = 0, osc = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, d0;
	logic [11:0] pend = 12'h000;
	logic req, high;
	logic [4:0] order;
	logic [15:0] vec, last_vec, en, pr;
	int failures = 0, checked = 0, cycles = 0, calls, c0;
	eiv_vectoring u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
		.i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_src_pending(pend), .i_rtc_alarm_evt(alarm),
		.i_rtc_osc_fail_evt(oscf), .o_irq_req(req), .o_irq_high(high), .o_irq_vector(vec), .o_irq_order(order));
	eiv_core_model u_core (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_irq_req(req), .i_irq_vector(vec),
		.o_calls(calls), .o_last_vector(last_vec));
	initial forever #25 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(negedge i_clock) {addr, wdata, wr} = {a, v, 1'b1};
		@(negedge i_clock) wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(negedge i_clock) addr = a;
		@(negedge i_clock) v = rdata;
	endtask
	task automatic prog_regs(input logic g);
		wr_reg(eiv_pkg::ADDR_INT_ENABLE_PRIMARY, {g, 7'h00});
		wr_reg(eiv_pkg::ADDR_EXT_ENABLE_ONE, en[7:0]);
		wr_reg(eiv_pkg::ADDR_EXT_ENABLE_TWO, en[15:8]);
		wr_reg(eiv_pkg::ADDR_EXT_PRIORITY_ONE, pr[7:0]);
		wr_reg(eiv_pkg::ADDR_EXT_PRIORITY_TWO, pr[15:8]);
	endtask
	// Winner among gated requests: high priority first, then the lowest order.
	task automatic check_irq(input logic g);
		int best;
		best = -1;
		@(negedge i_clock);
		for (int k = 0; k < 12; k++)
			if (g && (k == 7 ? osc : pend[k]) && en[k+3] && k != 3 && k != 8)
				if (best < 0 || (pr[k+3] && !pr[best+3])) best = k;
		chk(req, best >= 0);
		if (best >= 0) begin
			chk(high, pr[best+3]);
			chk(order, 5'd10 + 5'(best));
			chk(vec, 16'h0053 + 16'(best) * 16'h0008);
		end
	endtask
	initial begin
		void'($urandom(32'h3d5c423f));
		repeat (5) @(posedge i_clock);
		@(negedge i_clock) i_rst_n = 1'b1;
		rd_reg(eiv_pkg::ADDR_INT_ENABLE_PRIMARY, d);
		chk(d, 8'h00);
		repeat (4) begin
			d0 = 8'($urandom);
			wr_reg(eiv_pkg::ADDR_INT_ENABLE_PRIMARY, d0);
			rd_reg(eiv_pkg::ADDR_INT_ENABLE_PRIMARY, d);
			chk(d, d0);
		end
		{en, pr} = {16'hfff8, 16'h0000};
		prog_regs(1'b1);
		for (int k = 0; k < 12; k++) begin
			pend = 12'h001 << k;
			check_irq(1'b1);
		end
		pend = 12'hfff;
		prog_regs(1'b0);
		check_irq(1'b0);
		repeat (30) begin
			{en, pr, pend} = {16'($urandom), 16'($urandom), 12'($urandom)};
			d0 = 8'($urandom);
			prog_regs(d0[0]);
			check_irq(d0[0]);
			check_irq(d0[0]);
		end
		{en, pr, pend} = {16'h0100, 16'h0000, 12'h020};
		prog_regs(1'b1);
		check_irq(1'b1);
		c0 = calls;
		repeat (16) @(negedge i_clock);
		chk(calls - c0 >= 2, 16'h0001);
		chk(last_vec, 16'h007b);
		en = 16'h0000;
		prog_regs(1'b1);
		check_irq(1'b1);
		{en, pr, pend} = {16'h0400, 16'h0400, 12'h080};
		prog_regs(1'b1);
		@(negedge i_clock) {oscf, alarm} = 2'b11;
		@(negedge i_clock) {oscf, alarm, osc} = 3'b001;
		check_irq(1'b1);
		@(negedge i_clock);
		chk(last_vec, 16'h008b);
		wr_reg(eiv_pkg::ADDR_RTC_INDEX, 8'h04);
		rd_reg(eiv_pkg::ADDR_RTC_DATA, d);
		chk({d[5], d[2]}, 2'b11);
		// A clear that meets a new failure event must leave the failure flag set.
		@(negedge i_clock) {addr, wdata, wr, oscf} = {eiv_pkg::ADDR_RTC_DATA, 8'h00, 1'b1, 1'b1};
		@(negedge i_clock) {wr, oscf} = 2'b00;
		rd_reg(eiv_pkg::ADDR_RTC_DATA, d);
		chk({d[5], d[2]}, 2'b10);
		wr_reg(eiv_pkg::ADDR_RTC_DATA, 8'h00);
		osc = 1'b0;
		check_irq(1'b1);
		wr_reg(eiv_pkg::ADDR_RTC_INDEX, 8'h05);
		rd_reg(eiv_pkg::ADDR_RTC_DATA, d);
		chk(d, 8'h00);
		end_sim();
	end
endmodule // eiv_vectoring_tb_top
